// *** sprc_sleep_power_reset_control.sv ***
// sleep mode control, peripheral clock gating, protected brown-out sleep disable
// and reset stretching for a small controller
// assumes a one-cycle register port, pulses for sleep and wake, sources on clk
`timescale 1ns/1ps
`include "sprc_consts.svh"

// What this block does
// - reserved control bit 5 and gate bits 7:5 read as zero.
// - setting brown-out sleep disable needs key write within four cycles.
// - brown-out detector off in sleep only if disable bit set at sleep.
// - waking clears the brown-out sleep disable bit.
// - writing zero clears the disable bit without the key.
// - mode field bits 3:1: idle, noise reduction, power-down, standby.
// - sleep request sleeps only while sleep enable bit 0 is one.
// - gate bits 4..0 stop clocks of two-wire, serial, timer1, timer0, converter.
// - released timer resumes from its frozen state.
// - gated converter blocks comparator use of its input multiplexer.
// - reset returns registers to initial values and restarts the processor.
// - port pins go safe at once on any reset source, clockless.
// - internal reset held a delay after all sources go inactive.
// - four sources: power-on, external pin, watchdog, brown-out.
// - power-on restarts the count on rise, resets at once on fall.
// - pin release waits the full delay before the processor runs.
// - pin ignored in power-on count; extends only if low at end.
// - watchdog pulse restarts the count, counting from its falling edge.
// - brown-out low resets at once; release waits for the delay.
// - each sleep mode stops its documented set of clocks.
// - a gated peripheral is frozen and its registers inaccessible.
// - brown-out detector re-enabled on wake, then about 60 us wait.
module sprc_sleep_power_reset_control #(
  parameter int TOUT_CYC = `SPRC_TOUT_CYC,
  parameter int WAKE_CYC = `SPRC_WAKE_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic [`SPRC_ADDR_W-1:0]    addr,
  input  wire logic [7:0]                 wdata,
  input  wire logic                       wr_en,
  input  wire logic                       rd_en,
  output logic      [7:0]                 rdata,
  input  wire logic                       sleep_instr,
  input  wire logic                       wake_event,
  input  wire sprc_pkg::sprc_rst_src_t    rst_src,
  output sprc_pkg::sprc_clk_en_t          clk_en,
  output sprc_pkg::sprc_periph_t          periph_clk_en,
  output sprc_pkg::sprc_periph_t          periph_access_en,
  output logic                            cmp_mux_allow,
  output logic                            bod_on,
  output logic      [1:0]                 ext_int_sense,
  output logic                            sleeping,
  output logic                            cpu_reset,
  output logic                            port_safe
);

  // mode decode shared by the sleep entry and the clock plan
  function automatic sprc_pkg::sprc_mode_t decode_mode(input logic [2:0] sm);
    sprc_pkg::sprc_mode_t m;
    m = sprc_pkg::SPRC_MODE_IDLE;
    case (sm)
      3'h0:    m = sprc_pkg::SPRC_MODE_IDLE;
      3'h1:    m = sprc_pkg::SPRC_MODE_ADCNR;
      3'h2:    m = sprc_pkg::SPRC_MODE_PDOWN;
      3'h4:    m = sprc_pkg::SPRC_MODE_STBY;
      default: m = sprc_pkg::SPRC_MODE_IDLE;
    endcase
    return m;
  endfunction : decode_mode

  function automatic sprc_pkg::sprc_clk_en_t clk_plan(
    input sprc_pkg::sprc_mode_t mode,
    input logic                 asleep
  );
    sprc_pkg::sprc_clk_en_t c;
    c = '{cpu: 1'b1, nvm: 1'b1, io: 1'b1, adc: 1'b1, osc: 1'b1};
    if (asleep) begin
      case (mode)
        sprc_pkg::SPRC_MODE_IDLE: begin
          c = '{cpu: 1'b0, nvm: 1'b0, io: 1'b1, adc: 1'b1, osc: 1'b1};
        end
        sprc_pkg::SPRC_MODE_ADCNR: begin
          c = '{cpu: 1'b0, nvm: 1'b0, io: 1'b0, adc: 1'b1, osc: 1'b1};
        end
        sprc_pkg::SPRC_MODE_PDOWN: begin
          c = '{cpu: 1'b0, nvm: 1'b0, io: 1'b0, adc: 1'b0, osc: 1'b0};
        end
        sprc_pkg::SPRC_MODE_STBY: begin
          c = '{cpu: 1'b0, nvm: 1'b0, io: 1'b0, adc: 1'b0, osc: 1'b1};
        end
        default: begin
          c = '{cpu: 1'b0, nvm: 1'b0, io: 1'b1, adc: 1'b1, osc: 1'b1};
        end
      endcase
    end
    return c;
  endfunction : clk_plan

  sprc_pkg::sprc_state_t   state_r;
  sprc_pkg::sprc_state_t   state_nxt;
  sprc_pkg::sprc_mode_t    mode_r;
  sprc_pkg::sprc_clk_en_t  clk_en_r;
  sprc_pkg::sprc_periph_t  periph_clk_en_r;
  sprc_pkg::sprc_periph_t  periph_access_en_r;

  logic [1:0]  isc_r;
  logic        brownout_sleep_disable_r;
  logic        brownout_sleep_disable_nxt;
  logic [2:0]  sm_r;
  logic        se_r;
  logic [4:0]  gate_r;
  logic [2:0]  window_r;
  logic        brownout_sleep_disable_slept_r;
  logic        bod_on_r;
  logic [15:0] wake_cnt_r;
  logic [7:0]  rdata_r;
  logic        cmp_mux_allow_r;
  logic        sleeping_r;
  logic        int_reset;

  // control reset word, split into its fields at reset
  localparam logic [7:0] CTRL_RST = `SPRC_CTRL_RST;

  sprc_reset_stretch #(
    .TOUT_CYC  (TOUT_CYC)
  ) u_stretch (
    .clk       (clk),
    .rst_n     (rst_n),
    .src       (rst_src),
    .bod_armed (bod_on_r),
    .int_reset (int_reset),
    .port_safe (port_safe)
  );

  // register port decode
  wire sel_ctrl   = (addr == `SPRC_OFF_CTRL);
  wire sel_gate   = (addr == `SPRC_OFF_GATE);
  wire sel_key    = (addr == `SPRC_OFF_KEY);
  wire wr_ctrl    = wr_en & sel_ctrl;
  wire wr_gate    = wr_en & sel_gate;
  wire key_ok     = wr_en & sel_key & (wdata == `SPRC_KEY_SIG);
  wire window_on  = (window_r != 3'h0);
  wire wr_brownout_sleep_disable    = wdata[`SPRC_BIT_BROWNOUT_SLEEP_DISABLE];
  wire [2:0] wr_sm = wdata[`SPRC_BIT_SM_HI:`SPRC_BIT_SM_LO];

  wire [7:0] ctrl_view = {isc_r, 1'b0, brownout_sleep_disable_r, sm_r, se_r};
  wire [7:0] gate_view = {3'h0, gate_r};
  wire [7:0] rd_mux    = sel_ctrl ? ctrl_view :
                         sel_gate ? gate_view :
                         sel_key  ? {7'h00, window_on} : 8'h00;

  // sleep sequencing
  wire in_run     = (state_r == sprc_pkg::SPRC_ST_RUN);
  wire sleep_go   = sleep_instr & in_run & se_r;
  wire wake_now   = wake_event & (state_r == sprc_pkg::SPRC_ST_SLEEP);
  wire wake_done  = (wake_cnt_r == 16'(WAKE_CYC));
  wire asleep_nxt = (state_nxt == sprc_pkg::SPRC_ST_SLEEP);
  wire settle_nxt = (state_nxt == sprc_pkg::SPRC_ST_WAKE);
  // the detector settle wait keeps the processor halted, as in idle
  wire halt_nxt   = asleep_nxt | settle_nxt;

  sprc_pkg::sprc_mode_t mode_nxt;
  assign mode_nxt = sleep_go ? decode_mode(sm_r) : mode_r;

  sprc_pkg::sprc_mode_t plan_mode;
  assign plan_mode = settle_nxt ? sprc_pkg::SPRC_MODE_IDLE : mode_nxt;

  sprc_pkg::sprc_clk_en_t clk_plan_nxt;
  assign clk_plan_nxt = clk_plan(plan_mode, halt_nxt);

  // off only while asleep after a sleep taken with the disable bit set
  wire brownout_sleep_disable_in_force = sleep_go ? brownout_sleep_disable_r : brownout_sleep_disable_slept_r;
  wire bod_on_nxt    = ~(asleep_nxt & brownout_sleep_disable_in_force);

  // peripheral clocks ride the io or converter domain, then the gate bits
  sprc_pkg::sprc_periph_t gate_nxt;
  sprc_pkg::sprc_periph_t domain_nxt;
  assign gate_nxt   = wr_gate ? wdata[4:0] : gate_r;
  assign domain_nxt = '{twi:  clk_plan_nxt.io,
                        spi:  clk_plan_nxt.io,
                        tim1: clk_plan_nxt.io,
                        tim0: clk_plan_nxt.io,
                        adc:  clk_plan_nxt.adc};

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sprc_pkg::SPRC_ST_RUN: begin
        if (sleep_go) begin
          state_nxt = sprc_pkg::SPRC_ST_SLEEP;
        end
      end
      sprc_pkg::SPRC_ST_SLEEP: begin
        if (wake_event) begin
          // detector needs its settle time only after it was switched off
          state_nxt = brownout_sleep_disable_slept_r ? sprc_pkg::SPRC_ST_WAKE
                                   : sprc_pkg::SPRC_ST_RUN;
        end
      end
      sprc_pkg::SPRC_ST_WAKE: begin
        if (wake_done) begin
          state_nxt = sprc_pkg::SPRC_ST_RUN;
        end
      end
      default: begin
        state_nxt = sprc_pkg::SPRC_ST_RUN;
      end
    endcase
  end

  // protected set; a set in the wake cycle wins over the wake clear
  always_comb begin
    brownout_sleep_disable_nxt = brownout_sleep_disable_r;
    if (wr_ctrl && wr_brownout_sleep_disable && window_on) begin
      brownout_sleep_disable_nxt = 1'b1;
    end else if (wake_now) begin
      brownout_sleep_disable_nxt = 1'b0;
    end else if (wr_ctrl && !wr_brownout_sleep_disable) begin
      brownout_sleep_disable_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      window_r <= 3'h0;
    end else if (int_reset) begin
      window_r <= 3'h0;
    end else if (key_ok) begin
      window_r <= `SPRC_KEY_WINDOW;
    end else if (wr_ctrl) begin
      window_r <= 3'h0;
    end else if (window_on) begin
      window_r <= window_r - 3'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      isc_r  <= CTRL_RST[`SPRC_BIT_ISC_HI:`SPRC_BIT_ISC_LO];
      sm_r   <= CTRL_RST[`SPRC_BIT_SM_HI:`SPRC_BIT_SM_LO];
      se_r   <= CTRL_RST[`SPRC_BIT_SE];
      brownout_sleep_disable_r <= CTRL_RST[`SPRC_BIT_BROWNOUT_SLEEP_DISABLE];
      gate_r <= `SPRC_GATE_RST;
    end else if (int_reset) begin
      isc_r  <= 2'h0;
      sm_r   <= 3'h0;
      se_r   <= 1'b0;
      brownout_sleep_disable_r <= 1'b0;
      gate_r <= `SPRC_GATE_RST;
    end else begin
      brownout_sleep_disable_r <= brownout_sleep_disable_nxt;
      gate_r <= gate_nxt;
      if (wr_ctrl) begin
        isc_r <= wdata[`SPRC_BIT_ISC_HI:`SPRC_BIT_ISC_LO];
        sm_r  <= wr_sm;
        se_r  <= wdata[`SPRC_BIT_SE];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r      <= sprc_pkg::SPRC_ST_RUN;
      mode_r       <= sprc_pkg::SPRC_MODE_IDLE;
      brownout_sleep_disable_slept_r <= 1'b0;
    end else if (int_reset) begin
      state_r      <= sprc_pkg::SPRC_ST_RUN;
      mode_r       <= sprc_pkg::SPRC_MODE_IDLE;
      brownout_sleep_disable_slept_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      mode_r  <= mode_nxt;
      if (sleep_go) begin
        brownout_sleep_disable_slept_r <= brownout_sleep_disable_r;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_cnt_r <= 16'h0000;
    end else if (state_r != sprc_pkg::SPRC_ST_WAKE) begin
      wake_cnt_r <= 16'h0000;
    end else if (!wake_done) begin
      wake_cnt_r <= wake_cnt_r + 16'h0001;
    end
  end

  // detector stays on through reset so brown-out can still trip
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bod_on_r <= 1'b1;
    end else if (int_reset) begin
      bod_on_r <= 1'b1;
    end else begin
      bod_on_r <= bod_on_nxt;
    end
  end

  // gating only drops the enable, so a timer holds its count until released
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_en_r           <= '{cpu: 1'b0, nvm: 1'b0, io: 1'b0, adc: 1'b0, osc: 1'b1};
      periph_clk_en_r    <= '0;
      periph_access_en_r <= '0;
      cmp_mux_allow_r    <= 1'b0;
      sleeping_r         <= 1'b0;
    end else if (int_reset) begin
      clk_en_r           <= '{cpu: 1'b0, nvm: 1'b0, io: 1'b0, adc: 1'b0, osc: 1'b1};
      periph_clk_en_r    <= '0;
      periph_access_en_r <= '0;
      cmp_mux_allow_r    <= 1'b0;
      sleeping_r         <= 1'b0;
    end else begin
      clk_en_r           <= clk_plan_nxt;
      periph_clk_en_r    <= domain_nxt & ~gate_nxt;
      periph_access_en_r <= ~gate_nxt;
      cmp_mux_allow_r    <= ~gate_nxt.adc;
      sleeping_r         <= (state_nxt != sprc_pkg::SPRC_ST_RUN);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rd_en ? rd_mux : 8'h00;
    end
  end

  assign rdata            = rdata_r;
  assign clk_en           = clk_en_r;
  assign periph_clk_en    = periph_clk_en_r;
  assign periph_access_en = periph_access_en_r;
  assign cmp_mux_allow    = cmp_mux_allow_r;
  assign bod_on           = bod_on_r;
  assign ext_int_sense    = isc_r;
  assign sleeping         = sleeping_r;
  assign cpu_reset        = int_reset;

endmodule : sprc_sleep_power_reset_control

// *** sprc_consts.svh ***
// offsets, field positions, reset values and timing counts of the sleep/power/reset block
// assumes an 8-bit register port with a 6-bit address and a 125 MHz clock
`ifndef SPRC_CONSTS_SVH
`define SPRC_CONSTS_SVH

`define SPRC_ADDR_W         6
`define SPRC_OFF_GATE       6'h35
`define SPRC_OFF_CTRL       6'h3a
`define SPRC_OFF_KEY        6'h3c
`define SPRC_KEY_SIG        8'hd8
`define SPRC_CTRL_RST       8'h00
`define SPRC_GATE_RST       5'h00
`define SPRC_BIT_SE         0
`define SPRC_BIT_SM_LO      1
`define SPRC_BIT_SM_HI      3
`define SPRC_BIT_BROWNOUT_SLEEP_DISABLE       4
`define SPRC_BIT_RSVD       5
`define SPRC_BIT_ISC_LO     6
`define SPRC_BIT_ISC_HI     7
`define SPRC_GATE_BITS      5
`define SPRC_KEY_WINDOW     3'h4
`define SPRC_CLK_MHZ        125
`define SPRC_TOUT_US        64
`define SPRC_WAKE_US        60
`define SPRC_TOUT_CYC       (`SPRC_TOUT_US * `SPRC_CLK_MHZ)
`define SPRC_WAKE_CYC       (`SPRC_WAKE_US * `SPRC_CLK_MHZ)

`endif

// *** sprc_pkg.sv ***
// types shared by the sleep/power/reset block
// constants live in sprc_consts.svh
package sprc_pkg;

  typedef enum logic [1:0] {
    SPRC_ST_RUN,
    SPRC_ST_SLEEP,
    SPRC_ST_WAKE
  } sprc_state_t;

  typedef enum logic [1:0] {
    SPRC_MODE_IDLE,
    SPRC_MODE_ADCNR,
    SPRC_MODE_PDOWN,
    SPRC_MODE_STBY
  } sprc_mode_t;

  typedef struct packed {
    logic cpu;
    logic nvm;
    logic io;
    logic adc;
    logic osc;
  } sprc_clk_en_t;

  // bit order matches the peripheral power gate register 4:0
  typedef struct packed {
    logic twi;
    logic spi;
    logic tim1;
    logic tim0;
    logic adc;
  } sprc_periph_t;

  typedef struct packed {
    logic por_low;
    logic ext_pin_n;
    logic ext_en;
    logic wdt_pulse;
    logic bod_low;
    logic bod_fuse_en;
  } sprc_rst_src_t;

endpackage : sprc_pkg

// *** sprc_reset_stretch.sv ***
// reset combiner and delay counter
// assumes reset source levels synchronous to clk; rst_n is the raw logic reset
`timescale 1ns/1ps
`include "sprc_consts.svh"

module sprc_reset_stretch #(
  parameter int TOUT_CYC = `SPRC_TOUT_CYC
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire sprc_pkg::sprc_rst_src_t src,
  input  wire logic                   bod_armed,
  output logic                        int_reset,
  output logic                        port_safe
);

  logic        por_phase_r;
  logic        int_reset_r;
  logic        port_safe_r;
  logic [15:0] cnt_r;

  wire ext_low    = src.ext_en & ~src.ext_pin_n;
  wire bod_trip   = src.bod_fuse_en & bod_armed & src.bod_low;
  // pin is ignored while the power-on count runs
  wire src_active = src.por_low | src.wdt_pulse | bod_trip
                  | (ext_low & ~por_phase_r);
  wire cnt_done   = (cnt_r == 16'(TOUT_CYC));
  wire release_ok = cnt_done & ~src_active & ~ext_low;
  wire any_src    = src.por_low | src.wdt_pulse | bod_trip | ext_low;
  // async clear so pins go safe with no running clock
  wire hard_rst_n = rst_n & ~any_src;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 16'h0000;
    end else if (src_active) begin
      cnt_r <= 16'h0000;
    end else if (!cnt_done) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      por_phase_r <= 1'b1;
      int_reset_r <= 1'b1;
    end else begin
      por_phase_r <= src.por_low | (por_phase_r & ~cnt_done);
      int_reset_r <= src_active | ~release_ok;
    end
  end

  always_ff @(posedge clk or negedge hard_rst_n) begin
    if (!hard_rst_n) begin
      port_safe_r <= 1'b1;
    end else begin
      port_safe_r <= src_active | ~release_ok;
    end
  end

  assign int_reset = int_reset_r;
  assign port_safe = port_safe_r;

endmodule : sprc_reset_stretch

// *** sprc_sleep_power_reset_control_sva.sv ***
// concurrent checks on the ports of the sleep/power/reset block
// assumes one clock domain and the register map of sprc_consts.svh
`timescale 1ns/1ps
`include "sprc_consts.svh"

module sprc_sleep_power_reset_control_sva #(
  parameter int TOUT_CYC = `SPRC_TOUT_CYC,
  parameter int WAKE_CYC = `SPRC_WAKE_CYC
) (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic [`SPRC_ADDR_W-1:0] addr,
  input wire logic [7:0]              wdata,
  input wire logic                    wr_en,
  input wire logic                    rd_en,
  input wire logic [7:0]              rdata,
  input wire logic                    sleep_instr,
  input wire logic                    wake_event,
  input wire sprc_pkg::sprc_rst_src_t rst_src,
  input wire sprc_pkg::sprc_clk_en_t  clk_en,
  input wire sprc_pkg::sprc_periph_t  periph_clk_en,
  input wire sprc_pkg::sprc_periph_t  periph_access_en,
  input wire logic                    cmp_mux_allow,
  input wire logic                    bod_on,
  input wire logic [1:0]              ext_int_sense,
  input wire logic                    sleeping,
  input wire logic                    cpu_reset,
  input wire logic                    port_safe
);
  localparam int WAKE_MAX = WAKE_CYC + 3;
  logic [15:0] quiet_r;
  logic [15:0] quiet_nxt;
  logic        bod_q_r;
  logic [15:0] wake_wait_r;
  logic [15:0] wake_wait_nxt;
  // pin source left out: it is ignored in the power-on count
  wire         hard_src = rst_src.por_low | rst_src.wdt_pulse |
                          (rst_src.bod_low & rst_src.bod_fuse_en & bod_on);

  assign quiet_nxt = hard_src ? 16'h0000 : (quiet_r == 16'hffff ? quiet_r : quiet_r + 16'h0001);
  // cycles still asleep since the detector came back on at wake
  assign wake_wait_nxt = (sleeping && bod_on && (!bod_q_r || wake_wait_r != 16'h0000)) ?
                         wake_wait_r + 16'h0001 : 16'h0000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quiet_r     <= 16'h0000;
      bod_q_r     <= 1'b1;
      wake_wait_r <= 16'h0000;
    end else begin
      quiet_r     <= quiet_nxt;
      bod_q_r     <= bod_on;
      wake_wait_r <= wake_wait_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_rsvd_ctrl_zero: assert property (rd_en && addr == `SPRC_OFF_CTRL |=> rdata[5] == 1'b0)
    else $error("reserved control bit read as one");
  a_rsvd_gate_zero: assert property (rd_en && addr == `SPRC_OFF_GATE |=> rdata[7:5] == 3'b000)
    else $error("reserved gate bits read as nonzero");
  a_rdata_quiet: assert property (!rd_en |=> rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_sleep_needs_instr: assert property ($rose(sleeping) |-> $past(sleep_instr))
    else $error("sleep entered without a sleep request");
  a_sleep_halts_cpu: assert property ($rose(sleeping) |-> !clk_en.cpu && !clk_en.nvm)
    else $error("processor clocks running in sleep");
  a_bod_off_asleep: assert property (!bod_on |-> sleeping)
    else $error("detector off while awake");
  a_wake_bounded: assert property (wake_wait_r <= WAKE_MAX)
    else $error("wake wait after detector restart too long");
  a_cpu_held_asleep: assert property (sleeping |-> !clk_en.cpu && !clk_en.nvm)
    else $error("processor clocked before the wake wait ended");
  a_cmp_follows_gate: assert property (cmp_mux_allow == periph_access_en.adc)
    else $error("comparator mux permission disagrees with converter gate");
  a_gated_no_clock: assert property ((periph_clk_en & ~periph_access_en) == 5'h00)
    else $error("gated peripheral still clocked");
  a_safe_on_src: assert property (hard_src |-> port_safe)
    else $error("ports not safe while a source is active");
  a_src_resets: assert property (hard_src |=> cpu_reset)
    else $error("active source did not reset the processor");
  a_reset_stretch: assert property ($fell(cpu_reset) |-> quiet_r >= TOUT_CYC)
    else $error("internal reset released before the delay");
  a_reset_holds: assert property (cpu_reset && $past(cpu_reset) |-> !sleeping && periph_access_en == 5'h00)
    else $error("outputs left initial values during reset");

  c_sleep: cover property ($rose(sleeping));
  c_bod_off: cover property ($fell(bod_on));
  c_release: cover property ($fell(cpu_reset));
  c_gate_read: cover property (rd_en && addr == `SPRC_OFF_GATE);
endmodule : sprc_sleep_power_reset_control_sva

bind sprc_sleep_power_reset_control sprc_sleep_power_reset_control_sva #(
  .TOUT_CYC(TOUT_CYC), .WAKE_CYC(WAKE_CYC)
) u_sprc_sva (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
  .rdata(rdata), .sleep_instr(sleep_instr), .wake_event(wake_event), .rst_src(rst_src),
  .clk_en(clk_en), .periph_clk_en(periph_clk_en), .periph_access_en(periph_access_en),
  .cmp_mux_allow(cmp_mux_allow), .bod_on(bod_on), .ext_int_sense(ext_int_sense),
  .sleeping(sleeping), .cpu_reset(cpu_reset), .port_safe(port_safe)
);

// *** testbench.sv ***
// self-checking bench for the sleep/power/reset block
// assumes short delay counts handed in through the parameters below
`timescale 1ns/1ps
`include "sprc_consts.svh"

module testbench;
  localparam int TOUT = 8;
  localparam int WAKE = 5;
  logic                    clk = 1'b0;
  logic                    rst_n = 1'b0;
  logic [5:0]              addr = 6'h00;
  logic [7:0]              wdata = 8'h00;
  logic                    wr_en = 1'b0;
  logic                    rd_en = 1'b0;
  logic [7:0]              rdata;
  logic                    sleep_instr = 1'b0;
  logic                    wake_event = 1'b0;
  sprc_pkg::sprc_rst_src_t rst_src = 6'b011001;
  sprc_pkg::sprc_clk_en_t  clk_en;
  sprc_pkg::sprc_periph_t  periph_clk_en;
  sprc_pkg::sprc_periph_t  periph_access_en;
  logic                    cmp_mux_allow;
  logic                    bod_on;
  logic [1:0]              ext_int_sense;
  logic                    sleeping;
  logic                    cpu_reset;
  logic                    port_safe;
  int                      miscompares = 0;
  int                      compares = 0;
  int                      n;
  logic [7:0]              d;
  logic [7:0]              e;
  logic [7:0]              q;
  logic [5:0]              a;

  always #4 clk = ~clk;

  sprc_sleep_power_reset_control #(.TOUT_CYC(TOUT), .WAKE_CYC(WAKE)) u_sprc_sleep_power_reset_control (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .sleep_instr(sleep_instr), .wake_event(wake_event), .rst_src(rst_src),
    .clk_en(clk_en), .periph_clk_en(periph_clk_en), .periph_access_en(periph_access_en),
    .cmp_mux_allow(cmp_mux_allow), .bod_on(bod_on), .ext_int_sense(ext_int_sense),
    .sleeping(sleeping), .cpu_reset(cpu_reset), .port_safe(port_safe));

  function automatic logic [4:0] exp_clk(input int m);
    case (m)
      1: return 5'h03;
      2: return 5'h00;
      4: return 5'h01;
      default: return 5'h07;
    endcase
  endfunction : exp_clk

  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // one bus cycle; strobes stay up until the next call lowers them
  task automatic cyc(input logic w, input logic r, input logic [5:0] ad, input logic [7:0] v);
    wr_en <= w;
    rd_en <= r;
    addr  <= ad;
    wdata <= v;
    @(posedge clk);
  endtask : cyc

  task automatic wr(input logic [5:0] ad, input logic [7:0] v);
    cyc(1'b1, 1'b0, ad, v);
  endtask : wr

  task automatic idle();
    cyc(1'b0, 1'b0, addr, 8'h00);
  endtask : idle

  task automatic rd(input logic [5:0] ad, output logic [7:0] v);
    cyc(1'b0, 1'b1, ad, 8'h00);
    rd_en <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask : rd

  task automatic pulse(input logic wake);
    idle();
    if (wake) wake_event <= 1'b1;
    else sleep_instr <= 1'b1;
    @(posedge clk);
    wake_event  <= 1'b0;
    sleep_instr <= 1'b0;
    #1;
  endtask : pulse

  task automatic drive_src(input int i, input logic on);
    case (i)
      0: rst_src.por_low <= on;
      1: rst_src.wdt_pulse <= on;
      2: rst_src.bod_low <= on;
      default: rst_src.ext_pin_n <= ~on;
    endcase
  endtask : drive_src

  // pin goes high two cycles in, so a low pin inside a power-on count is shown to be ignored
  task automatic settle_count(output int cnt);
    cnt = 0;
    while (cpu_reset !== 1'b0 && cnt < 100) begin
      @(posedge clk);
      cnt++;
      if (cnt == 2) rst_src.ext_pin_n <= 1'b1;
      #1;
    end
    check({7'h00, cnt >= TOUT && cnt <= TOUT + 2}, 8'h01);
    @(posedge clk);
  endtask : settle_count

  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    close_out();
  end

  initial begin
    void'($urandom(32'h971c9b85));
    repeat (3) @(posedge clk);
    #1 check({port_safe, cpu_reset, bod_on, clk_en}, 8'he1);
    @(posedge clk);
    rst_n <= 1'b1;
    #1 settle_count(n);
    rd(`SPRC_OFF_CTRL, q);
    check(q, `SPRC_CTRL_RST);
    for (int i = 0; i < 24; i++) begin
      d = (i == 0) ? 8'hff : 8'($urandom);
      e = d & 8'hcf;
      wr(`SPRC_OFF_CTRL, d);
      wr(`SPRC_OFF_GATE, d); // converter taken as idle before gating
      rd(`SPRC_OFF_CTRL, q);
      check(q, e);
      rd(`SPRC_OFF_GATE, q);
      check(q, d & 8'h1f);
      #1 check({3'b000, periph_access_en}, ~d & 8'h1f);
      check({3'b000, periph_clk_en}, ~d & 8'h1f);
      check({cmp_mux_allow, 5'h00, ext_int_sense}, {~d[0], 5'h00, d[7:6]});
      @(posedge clk);
    end
    a = {2'b00, 4'($urandom)};
    wr(a, 8'hff);
    rd(a, q);
    check(q, 8'h00);
    rd(`SPRC_OFF_CTRL, q);
    check(q, e);
    for (int g = 0; g <= 5; g++) begin
      wr(`SPRC_OFF_KEY, g == 0 ? 8'hd9 : `SPRC_KEY_SIG);
      repeat (g == 0 ? 0 : g - 1) idle();
      wr(`SPRC_OFF_CTRL, 8'h10);
      rd(`SPRC_OFF_CTRL, q);
      check(q, (g >= 1 && g <= 4) ? 8'h10 : 8'h00);
      wr(`SPRC_OFF_CTRL, 8'h00);
      rd(`SPRC_OFF_CTRL, q);
      check(q, 8'h00);
    end
    wr(`SPRC_OFF_CTRL, 8'h04);
    pulse(1'b0);
    check({2'b00, sleeping, clk_en}, 8'h1f);
    @(posedge clk);
    for (int m = 0; m < 8; m++) begin
      wr(`SPRC_OFF_CTRL, {4'h0, 3'(m), 1'b1});
      pulse(1'b0);
      check({1'b0, bod_on, sleeping, clk_en}, {3'b011, exp_clk(m)});
      @(posedge clk);
      pulse(1'b1);
      check({2'b00, sleeping, clk_en}, 8'h1f);
      @(posedge clk);
      wr(`SPRC_OFF_CTRL, 8'h00);
    end
    wr(`SPRC_OFF_KEY, `SPRC_KEY_SIG);
    wr(`SPRC_OFF_CTRL, 8'h15);
    pulse(1'b0);
    check({7'h00, bod_on}, 8'h00);
    @(posedge clk);
    pulse(1'b1);
    check({bod_on, sleeping, 1'b0, clk_en}, 8'hc7);
    n = 1;
    while (sleeping !== 1'b0 && n < 50) begin
      @(posedge clk);
      #1 n++;
    end
    check({7'h00, n >= WAKE && n <= WAKE + 2}, 8'h01);
    check({2'b00, sleeping, clk_en}, 8'h1f);
    @(posedge clk);
    rd(`SPRC_OFF_CTRL, q);
    check(q, 8'h05);
    for (int i = 0; i < 4; i++) begin
      wr(`SPRC_OFF_GATE, 8'h1f);
      idle();
      drive_src(i, 1'b1);
      #1 check({7'h00, port_safe}, 8'h01);
      repeat (i == 1 ? 1 : 1 + $urandom % 4) @(posedge clk);
      drive_src(i, 1'b0);
      #1 check({7'h00, cpu_reset}, 8'h01);
      settle_count(n);
      rd(`SPRC_OFF_GATE, q);
      check(q, 8'h00);
    end
    rst_src.bod_fuse_en <= 1'b0;
    rst_src.ext_en <= 1'b0;
    drive_src(2, 1'b1);
    drive_src(3, 1'b1);
    repeat (4) @(posedge clk);
    #1 check({6'h00, port_safe, cpu_reset}, 8'h00);
    @(posedge clk);
    drive_src(2, 1'b0);
    drive_src(3, 1'b0);
    rst_src.bod_fuse_en <= 1'b1;
    rst_src.ext_en <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      rst_src.por_low <= 1'b1;
      rst_src.ext_pin_n <= 1'b0;
      @(posedge clk);
      rst_src.por_low <= 1'b0;
      if (k == 0) begin
        repeat (TOUT + 6) @(posedge clk);
        #1 check({7'h00, cpu_reset}, 8'h01);
        @(posedge clk);
        rst_src.ext_pin_n <= 1'b1;
      end
      #1 settle_count(n);
    end
    close_out();
  end
endmodule : testbench
